/* design/nand_host_regs.vh */
`ifndef NAND_HOST_REGS_VH
`define NAND_HOST_REGS_VH
// ------------------------------------------------------------
// Commands and geometry
// ------------------------------------------------------------
`define CMD_READ_ID 8'h90
`define CMD_READ_1 8'h00
`define CMD_READ_2 8'h30
`define CMD_PROG_1 8'h80
`define CMD_PROG_2 8'h10
`define CMD_ERASE_1 8'h60
`define CMD_ERASE_2 8'hD0
`define ADDR_ID 8'h00
`define PAGE_MAIN_BYTES 2048
`define PAGE_SPARE_BYTES 128
`define PAGE_COLUMNS 2176
`define PAGES_PER_BLOCK 64
`define BLOCKS_PER_PLANE 2048
`define PLANES_PER_DIE 2
`define DIES_PER_STACK 4
`define ID_BYTES 5
`define ADDR_BYTES 5
// Upper nibble of column byte 2 and row byte 3 is held low
`define HI_NIBBLE_MASK 8'h0F
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STROBE_CYC 3
`define READ_MAX_US 30
`define PROG_TYP_US 300
`define ERASE_TYP_US 3500
`define READ_WAIT_CYC (`READ_MAX_US * 1000 / `CLK_PERIOD_NS)
`define PROG_WAIT_CYC (`PROG_TYP_US * 1000 / `CLK_PERIOD_NS)
`define ERASE_WAIT_CYC (`ERASE_TYP_US * 1000 / `CLK_PERIOD_NS)
`endif

/* design/nand_strobe_timer.v */
`timescale 1ns/1ns
`default_nettype none
module nand_strobe_timer (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_start,
	input wire [21:0] i_count,
	output wire o_done
);
	reg [21:0] cnt_reg;
	reg run_reg;
	assign o_done = run_reg && (cnt_reg == 22'h000000);
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			cnt_reg <= 22'h000000;
			run_reg <= 1'b0;
		end else if (i_start) begin
			cnt_reg <= i_count;
			run_reg <= 1'b1;
		end else if (o_done) begin
			run_reg <= 1'b0;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg - 22'h000001;
		end
	end
endmodule
`default_nettype wire

/* design/nand_host_ctrl.v */
// Notes on behaviour
// - One shared 8-bit bus, bytes in turn
// - Command latched at write strobe rise
// - Address latched at write strobe rise
// - Host holds bytes stable across strobe rise
// - Select low addresses the stack
// - Four dies share bus and select
// - Five address bytes for read and program, three row bytes for erase, unused high bits low
// - ID mode: 90h then 00h, five bytes
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_regs.vh"
module nand_host_ctrl #(
	parameter ERASE_WAIT = `ERASE_WAIT_CYC
) (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_op_valid,
	input wire [1:0] i_op_kind,
	input wire [39:0] i_op_addr,
	input wire i_protect_n,
	output wire o_op_ready,
	input wire i_wr_valid,
	input wire [7:0] i_wr_data,
	output wire o_wr_ready,
	output reg o_rd_valid,
	output reg [7:0] o_rd_data,
	output reg o_done,
	output reg o_timeout,
	input wire [7:0] i_bus_lines,
	output reg [7:0] o_bus_lines,
	output reg o_bus_lines_oe,
	output reg o_cmd_latch,
	output reg o_addr_latch,
	output reg o_chip_sel_n,
	output reg o_write_strobe_n,
	output reg o_read_strobe_n,
	output reg o_protect_n,
	input wire i_ready_busy_n
);
	// ------------------------------------------------------------
	// Operations and states
	// ------------------------------------------------------------
	localparam OP_ID = 2'd0;
	localparam OP_READ = 2'd1;
	localparam OP_PROG = 2'd2;
	localparam OP_ERASE = 2'd3;
	localparam S_IDLE = 3'd0;
	localparam S_CMD1 = 3'd1;
	localparam S_ADDR = 3'd2;
	localparam S_WDATA = 3'd3;
	localparam S_CMD2 = 3'd4;
	localparam S_WAIT = 3'd5;
	localparam S_RDATA = 3'd6;
	localparam S_END = 3'd7;
	// Counts are 32-bit integers; cut to the counter widths on purpose
	localparam integer STROBE_I = `STROBE_CYC;
	localparam integer RD_WAIT_I = `READ_WAIT_CYC;
	localparam integer PR_WAIT_I = `PROG_WAIT_CYC;
	localparam integer ER_WAIT_I = ERASE_WAIT;
	localparam integer COLS_I = `PAGE_COLUMNS;
	localparam integer ID_N_I = `ID_BYTES;
	localparam [21:0] STROBE = STROBE_I[21:0];
	localparam [21:0] RD_WAIT = RD_WAIT_I[21:0];
	localparam [21:0] PR_WAIT = PR_WAIT_I[21:0];
	localparam [21:0] ER_WAIT = ER_WAIT_I[21:0];
	localparam [11:0] COLS = COLS_I[11:0];
	localparam [11:0] ID_N = ID_N_I[11:0];

	reg [2:0] state_reg;
	reg [1:0] kind_reg;
	reg [39:0] addr_reg;
	reg [2:0] acnt_reg;
	reg [11:0] bcnt_reg;
	reg phase_reg;
	reg start_reg;
	reg [21:0] load_reg;
	wire tdone;

	nand_strobe_timer u_timer (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_start(start_reg),
		.i_count(load_reg),
		.o_done(tdone)
	);

	// Ops that modify are refused up front while protect is low
	wire op_ok = (i_op_kind == OP_ID) || (i_op_kind == OP_READ) ||
		i_protect_n;
	assign o_op_ready = (state_reg == S_IDLE) && op_ok;
	assign o_wr_ready = (state_reg == S_WDATA) && !phase_reg &&
		!start_reg && !tdone && o_write_strobe_n;

	// Address byte n with unused high bits forced low
	reg [7:0] abyte;
	always @* begin
		abyte = addr_reg[7:0];
		case (acnt_reg)
		3'd1: abyte = addr_reg[15:8] & `HI_NIBBLE_MASK;
		3'd2: abyte = addr_reg[23:16];
		3'd3: abyte = addr_reg[31:24];
		3'd4: abyte = addr_reg[39:32] & `HI_NIBBLE_MASK;
		default: abyte = addr_reg[7:0];
		endcase
	end

	wire [7:0] cmd1 = (kind_reg == OP_ID) ? `CMD_READ_ID :
		(kind_reg == OP_READ) ? `CMD_READ_1 :
		(kind_reg == OP_PROG) ? `CMD_PROG_1 : `CMD_ERASE_1;
	wire [7:0] cmd2 = (kind_reg == OP_READ) ? `CMD_READ_2 :
		(kind_reg == OP_PROG) ? `CMD_PROG_2 : `CMD_ERASE_2;
	// Erase starts at the first row byte, so all but ID end on byte 4
	wire [2:0] alast = (kind_reg == OP_ID) ? 3'd0 : 3'd4;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Each strobe: phase 0 drives low STROBE+2 cycles, phase 1 high.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_reg <= S_IDLE;
			kind_reg <= 2'd0;
			addr_reg <= 40'h0000000000;
			acnt_reg <= 3'd0;
			bcnt_reg <= 12'h000;
			phase_reg <= 1'b0;
			start_reg <= 1'b0;
			load_reg <= 22'h000000;
			o_rd_valid <= 1'b0;
			o_rd_data <= 8'h00;
			o_done <= 1'b0;
			o_timeout <= 1'b0;
			o_bus_lines <= 8'h00;
			o_bus_lines_oe <= 1'b0;
			o_cmd_latch <= 1'b0;
			o_addr_latch <= 1'b0;
			o_chip_sel_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_read_strobe_n <= 1'b1;
			o_protect_n <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			o_rd_valid <= 1'b0;
			o_done <= 1'b0;
			o_protect_n <= i_protect_n;
			case (state_reg)
			S_IDLE: begin
				o_chip_sel_n <= 1'b1;
				o_bus_lines_oe <= 1'b0;
				if (i_op_valid && op_ok) begin
					kind_reg <= i_op_kind;
					addr_reg <= i_op_addr;
					o_timeout <= 1'b0;
					// Select the whole stack; die is in row bits
					o_chip_sel_n <= 1'b0;
					// Erase carries the row bytes only
					acnt_reg <= (i_op_kind == OP_ERASE) ? 3'd2 : 3'd0;
					phase_reg <= 1'b0;
					state_reg <= S_CMD1;
				end
			end
			S_CMD1, S_CMD2, S_ADDR: begin
				if (!phase_reg && o_write_strobe_n && !start_reg &&
					!tdone) begin
					// Byte driven at the same edge that drops the strobe
					o_bus_lines_oe <= 1'b1;
					o_cmd_latch <= (state_reg != S_ADDR);
					o_addr_latch <= (state_reg == S_ADDR);
					o_bus_lines <= (state_reg == S_CMD1) ? cmd1 :
						(state_reg == S_CMD2) ? cmd2 :
						(kind_reg == OP_ID) ? `ADDR_ID : abyte;
					o_write_strobe_n <= 1'b0;
					start_reg <= 1'b1;
					load_reg <= STROBE;
				end else if (tdone && !phase_reg) begin
					// Rising edge latches the byte held on the bus
					o_write_strobe_n <= 1'b1;
					phase_reg <= 1'b1;
					start_reg <= 1'b1;
					load_reg <= STROBE;
				end else if (tdone) begin
					phase_reg <= 1'b0;
					o_cmd_latch <= 1'b0;
					o_addr_latch <= 1'b0;
					if (state_reg == S_CMD1) begin
						state_reg <= S_ADDR;
					end else if (state_reg == S_CMD2) begin
						state_reg <= S_WAIT;
						o_bus_lines_oe <= 1'b0;
						start_reg <= 1'b1;
						load_reg <= (kind_reg == OP_READ) ? RD_WAIT :
							(kind_reg == OP_PROG) ? PR_WAIT : ER_WAIT;
					end else if (acnt_reg != alast) begin
						acnt_reg <= acnt_reg + 3'd1;
					end else if (kind_reg == OP_ID) begin
						o_bus_lines_oe <= 1'b0;
						bcnt_reg <= ID_N;
						state_reg <= S_RDATA;
					end else if (kind_reg == OP_PROG) begin
						bcnt_reg <= COLS;
						state_reg <= S_WDATA;
					end else begin
						state_reg <= S_CMD2;
					end
				end
			end
			S_WDATA: begin
				if (i_wr_valid && o_wr_ready) begin
					o_bus_lines <= i_wr_data;
					o_write_strobe_n <= 1'b0;
					start_reg <= 1'b1;
					load_reg <= STROBE;
				end else if (tdone && !phase_reg) begin
					o_write_strobe_n <= 1'b1;
					phase_reg <= 1'b1;
					start_reg <= 1'b1;
					load_reg <= STROBE;
					bcnt_reg <= bcnt_reg - 12'h001;
				end else if (tdone) begin
					phase_reg <= 1'b0;
					if (bcnt_reg == 12'h000) begin
						state_reg <= S_CMD2;
					end
				end
			end
			S_WAIT: begin
				// Ready high after busy was seen low ends the wait; timer is a give-up bound
				if (i_ready_busy_n && !start_reg && !tdone &&
					load_reg != RD_WAIT && load_reg != PR_WAIT &&
					load_reg != ER_WAIT) begin
					state_reg <= (kind_reg == OP_READ) ? S_RDATA : S_END;
					bcnt_reg <= COLS;
				end else if (tdone) begin
					o_timeout <= 1'b1;
					state_reg <= S_END;
				end else if (!i_ready_busy_n) begin
					load_reg <= 22'h000000;
				end
			end
			S_RDATA: begin
				if (!phase_reg && o_read_strobe_n && !start_reg &&
					!tdone) begin
					o_read_strobe_n <= 1'b0;
					start_reg <= 1'b1;
					load_reg <= STROBE;
				end else if (tdone && !phase_reg) begin
					// Sample before rise; first ID byte is maker
					o_rd_data <= i_bus_lines;
					o_rd_valid <= 1'b1;
					o_read_strobe_n <= 1'b1;
					phase_reg <= 1'b1;
					start_reg <= 1'b1;
					load_reg <= STROBE;
					bcnt_reg <= bcnt_reg - 12'h001;
				end else if (tdone) begin
					phase_reg <= 1'b0;
					if (bcnt_reg == 12'h000) begin
						state_reg <= S_END;
					end
				end
			end
			S_END: begin
				o_done <= 1'b1;
				o_chip_sel_n <= 1'b1;
				state_reg <= S_IDLE;
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* tb/nand_host_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pin protocol checks
// ----------------------------------------
module nand_host_props (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_protect_n,
	input wire logic i_ready_busy_n,
	input wire logic [1:0] i_op_kind,
	input wire logic [7:0] o_bus_lines,
	input wire logic o_op_ready,
	input wire logic o_rd_valid,
	input wire logic o_done,
	input wire logic o_bus_lines_oe,
	input wire logic o_cmd_latch,
	input wire logic o_addr_latch,
	input wire logic o_chip_sel_n,
	input wire logic o_write_strobe_n,
	input wire logic o_read_strobe_n,
	input wire logic o_protect_n
);
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (i_reset);
a_latch_excl: assert property (!(o_cmd_latch && o_addr_latch))
	else $error("both latches high");
a_strobe_excl: assert property (o_write_strobe_n || o_read_strobe_n)
	else $error("both strobes low");
a_latch_drive: assert property ((o_cmd_latch || o_addr_latch) &&
	!o_write_strobe_n |-> o_bus_lines_oe) else $error("latch undriven");
a_rise_stable: assert property ($rose(o_write_strobe_n) |->
	o_bus_lines_oe && $stable(o_bus_lines)) else $error("byte moved");
a_write_sel: assert property (!o_write_strobe_n |-> !o_chip_sel_n)
	else $error("write unselected");
a_read_sel: assert property (!o_read_strobe_n |->
	!o_chip_sel_n && !o_bus_lines_oe) else $error("read clash");
a_refuse_op: assert property (!i_protect_n && i_op_kind[1] |->
	!o_op_ready) else $error("protected op offered");
a_rd_pulse: assert property (o_rd_valid |=> !o_rd_valid)
	else $error("read pulse too long");
a_busy_hold: assert property (!i_ready_busy_n |->
	o_write_strobe_n && o_read_strobe_n) else $error("strobe while busy");
a_protect_copy: assert property (!$past(i_reset) |->
	o_protect_n == $past(i_protect_n)) else $error("protect not copied");
c_done: cover property (o_done);
c_rd: cover property (o_rd_valid);
c_busy: cover property ($fell(i_ready_busy_n));
endmodule
bind nand_host_ctrl nand_host_props u_props (
	.i_sys_clk(i_sys_clk),
	.i_reset(i_reset),
	.i_protect_n(i_protect_n),
	.i_ready_busy_n(i_ready_busy_n),
	.i_op_kind(i_op_kind),
	.o_bus_lines(o_bus_lines),
	.o_op_ready(o_op_ready),
	.o_rd_valid(o_rd_valid),
	.o_done(o_done),
	.o_bus_lines_oe(o_bus_lines_oe),
	.o_cmd_latch(o_cmd_latch),
	.o_addr_latch(o_addr_latch),
	.o_chip_sel_n(o_chip_sel_n),
	.o_write_strobe_n(o_write_strobe_n),
	.o_read_strobe_n(o_read_strobe_n),
	.o_protect_n(o_protect_n)
);
`default_nettype wire

/* tb/nand_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Stack model, busy kept short for sim
// ----------------------------------------
module nand_dev_model #(
	parameter logic [7:0] MAKER = 8'hA7 // Arbitrary value
) (
	input wire logic cle, ale, ce_n, we_n, read_strobe_n, wp_n,
	input wire logic [7:0] d,
	output logic [7:0] q,
	output logic rb_n
);
	logic [7:0] adr [0:4];
	logic [11:0] col;
	logic [13:0] blk;
	logic [5:0] pg;
	int na = 0, nw = 0, sum = 0, k = 0;
	bit idm = 0;
	// Set by the bench: stack ignores every write strobe
	bit lockout_active = 0;
	initial begin
		q = 8'h00;
		rb_n = 1'b1;
	end
	always @(posedge we_n) if (!ce_n && !lockout_active) begin
		if (cle) begin
			if (!(d inside {8'h30, 8'h10, 8'hD0})) begin
				idm = (d == 8'h90);
				// Erase has no column bytes: its row lands in slots 2..4
				na = (d == 8'h60) ? 2 : 0;
				nw = 0;
				sum = 0;
				k = 0;
			end
			if (d == 8'h30 || (wp_n && (d == 8'h10 || d == 8'hD0))) begin
				rb_n = 1'b0;
				#200 rb_n = 1'b1;
			end
		end else if (ale) begin
			if (na < 5) adr[na] = d;
			if (na == 1) col = {d[3:0], adr[0]};
			if (na == 4) begin
				pg = adr[2][5:0];
				blk = {d[3:0], adr[3], adr[2][7:6]};
			end
			na++;
		end else begin
			nw++;
			sum += d;
		end
	end
	always @(negedge read_strobe_n) if (!ce_n) begin
		q = idm ? MAKER ^ k[7:0] : col[7:0];
		k++;
		col++;
	end
	// No pull on the bus: a released line shows a changed value
	always @(posedge read_strobe_n) #20 q = ~q;
endmodule
`default_nettype wire

/* tb/tb_nand_host_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_nand_host_ctrl;
	localparam logic [7:0] MAKER = 8'hA7; // Arbitrary value
	logic i_sys_clk = 0, i_reset = 1, i_op_valid = 0, i_wr_valid = 0;
	logic i_protect_n = 1;
	logic [1:0] i_op_kind = 0;
	logic [39:0] i_op_addr = 0, a;
	logic [7:0] i_wr_data = 0, q;
	logic i_ready_busy_n;
	wire [7:0] o_rd_data, o_bus_lines;
	wire o_op_ready, o_wr_ready, o_rd_valid, o_done, o_timeout;
	wire o_bus_lines_oe, o_cmd_latch, o_addr_latch, o_chip_sel_n;
	wire o_write_strobe_n, o_read_strobe_n, o_protect_n;
	wire [7:0] i_bus_lines = o_bus_lines_oe ? o_bus_lines : q;
	int n_errors = 0, checks = 0, seed = 2, cyc = 0, nwr = 0, swr = 0;
	bit tk = 0;
	logic [7:0] exq [$];
	logic [11:0] c;
	nand_host_ctrl #(.ERASE_WAIT(50)) u_dut (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_op_valid(i_op_valid),
		.i_op_kind(i_op_kind),
		.i_op_addr(i_op_addr),
		.i_protect_n(i_protect_n),
		.o_op_ready(o_op_ready),
		.i_wr_valid(i_wr_valid),
		.i_wr_data(i_wr_data),
		.o_wr_ready(o_wr_ready),
		.o_rd_valid(o_rd_valid),
		.o_rd_data(o_rd_data),
		.o_done(o_done),
		.o_timeout(o_timeout),
		.i_bus_lines(i_bus_lines),
		.o_bus_lines(o_bus_lines),
		.o_bus_lines_oe(o_bus_lines_oe),
		.o_cmd_latch(o_cmd_latch),
		.o_addr_latch(o_addr_latch),
		.o_chip_sel_n(o_chip_sel_n),
		.o_write_strobe_n(o_write_strobe_n),
		.o_read_strobe_n(o_read_strobe_n),
		.o_protect_n(o_protect_n),
		.i_ready_busy_n(i_ready_busy_n)
	);
	nand_dev_model #(.MAKER(MAKER)) u_dev (.cle(o_cmd_latch),
		.ale(o_addr_latch), .ce_n(o_chip_sel_n), .we_n(o_write_strobe_n),
		.read_strobe_n(o_read_strobe_n), .wp_n(o_protect_n),
		.d(i_bus_lines), .q(q), .rb_n(i_ready_busy_n));
	always #5 i_sys_clk = ~i_sys_clk;
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic run_op(logic [1:0] k, logic [39:0] ad, logic to);
		i_op_valid = 1; i_op_kind = k; i_op_addr = ad;
		while (!o_op_ready) begin @(posedge i_sys_clk); #1; end
		@(posedge i_sys_clk); #1 i_op_valid = 0;
		while (!o_done) begin @(posedge i_sys_clk); #1; end
		cmp("timeout", to, o_timeout);
		$display("op %0d done", k);
	endtask
	// The stream byte is taken at the edge after ready was seen
	always @(posedge i_sys_clk) begin
		#1;
		if (tk) begin
			nwr++;
			swr += i_wr_data;
			i_wr_data = $random(seed);
		end
		tk = i_wr_valid && o_wr_ready;
	end
	always @(posedge i_sys_clk) #1 if (o_rd_valid)
		// An unexpected byte is compared with a value no byte can have
		cmp("rd byte", exq.size() ? exq.pop_front() : 32'h100, o_rd_data);
	always @(posedge i_sys_clk) if (++cyc == 60000) begin
		n_errors++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge i_sys_clk);
		#1 i_reset = 0;
		for (int j = 0; j < 5; j++) exq.push_back(MAKER ^ j[7:0]);
		run_op(2'h0, 40'h0, 0);
		cmp("id left", 0, exq.size());
		a[31:0] = $random(seed);
		a[39:32] = $random(seed);
		c = {a[11:8], a[7:0]};
		for (int j = 0; j < 2176; j++) exq.push_back(8'(c + j[11:0]));
		run_op(2'h1, a, 0);
		cmp("rd left", 0, exq.size());
		for (int j = 0; j < 5; j++)
			cmp("addr", 8'(a >> 8 * j) & (j % 3 == 1 ? 8'h0F : 8'hFF),
				u_dev.adr[j]);
		i_wr_valid = 1;
		run_op(2'h2, a, 0);
		i_wr_valid = 0;
		cmp("wr count", nwr, u_dev.nw);
		cmp("page bytes", 2176, u_dev.nw);
		cmp("wr sum", swr, u_dev.sum);
		i_protect_n = 0; i_op_valid = 1; i_op_kind = 2'h3;
		repeat (20) @(posedge i_sys_clk) #1 cmp("refuse", 0, o_op_ready);
		cmp("protect pin", 0, o_protect_n);
		i_op_valid = 0; i_protect_n = 1;
		$display("refuse test done");
		// Fresh row, so bytes left from the program cannot pass
		a[31:0] = $random(seed);
		a[39:32] = $random(seed);
		run_op(2'h3, a, 0);
		cmp("row bytes", 5, u_dev.na);
		for (int j = 2; j < 5; j++)
			cmp("row", 8'(a >> 8 * j) & (j == 4 ? 8'h0F : 8'hFF),
				u_dev.adr[j]);
		cmp("page", a[21:16], u_dev.pg);
		cmp("block", {a[35:32], a[31:22]}, u_dev.blk);
		// Stack ignores the erase, so the host must give up
		u_dev.lockout_active = 1;
		run_op(2'h3, a, 1);
		u_dev.lockout_active = 0;
		close_out();
	end
endmodule
`default_nettype wire
